// file: rtl/mcr_pkg.sv
// constants and types shared by the midi control router
package mcr_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_SRCSEL = 8'h08;
  localparam logic [7:0] OFS_PROG = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_DEST0 = 8'h14;
  localparam logic [7:0] OFS_DEST1 = 8'h18;
  localparam logic [7:0] OFS_NOISE = 8'h1C;
  // control register fields
  localparam int CTRL_CHAN_LSB = 0;
  localparam int CTRL_THRU_BIT = 5;
  localparam int CTRL_SYNC_BIT = 6;
  localparam int CTRL_DEST_BIT = 7;
  localparam int CTRL_NOTE_BIT = 8;
  localparam logic [4:0] CHAN_ALL = 5'h00;
  localparam logic [4:0] CHAN_MAX = 5'h10;
  // midi status codes
  localparam logic [3:0] ST_NOTE_ON = 4'h9;
  localparam logic [3:0] ST_CC = 4'hB;
  localparam logic [3:0] ST_PC = 4'hC;
  localparam logic [7:0] SYS_SYSEX = 8'hF0;
  localparam logic [7:0] SYS_RT_LO = 8'hF8;
  localparam logic [7:0] SYS_CLOCK = 8'hF8;
  // controller numbers
  localparam logic [6:0] CC_VIB = 7'h01;
  localparam logic [6:0] CC_MIX = 7'h02;
  localparam logic [6:0] CC_GLIDE = 7'h05;
  localparam logic [6:0] CC_DATA = 7'h06;
  localparam logic [6:0] CC_VOL = 7'h07;
  localparam logic [6:0] CC_CUT_A = 7'h0B;
  localparam logic [6:0] CC_SUS = 7'h40;
  localparam logic [6:0] CC_GON = 7'h41;
  localparam logic [6:0] CC_BYP = 7'h42;
  localparam logic [6:0] CC_PDEC = 7'h43;
  localparam logic [6:0] CC_BTOG = 7'h45;
  localparam logic [6:0] CC_CUT_B = 7'h4A;
  localparam logic [6:0] CC_NRPN_L = 7'h62;
  localparam logic [6:0] CC_NRPN_M = 7'h63;
  localparam logic [6:0] CC_ON_TH = 7'h40;
  localparam logic [3:0] SLOT_NONE = 4'hF;
  // default controller values
  localparam logic [6:0] DEF_VIB = 7'h00;
  localparam logic [6:0] DEF_MIX = 7'h7F;
  localparam logic [6:0] DEF_GLIDE = 7'h00;
  localparam logic [6:0] DEF_VOL = 7'h7F;
  localparam logic [6:0] DEF_CUT = 7'h40;
  localparam logic [6:0] DEF_SUS = 7'h00;
  localparam logic [6:0] DEF_GON = 7'h7F;
  // shared rate control range
  localparam logic [6:0] RATE_MIN = 7'h00;
  localparam logic [6:0] SYNC_STEP_LO = 7'h01;
  localparam logic [6:0] SYNC_STEP_HI = 7'h0C;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  // tempo timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CLKS_PER_QN = 24;
  localparam int BPM_MIN = 30;
  localparam int BPM_MAX = 480;
  localparam int BPM_DFLT = 120;
  localparam longint CYC_PER_MIN = longint'(CLK_HZ) * 64'd60;
  localparam int TICK_MIN_DEF = int'(CYC_PER_MIN / longint'(BPM_MAX * CLKS_PER_QN));
  localparam int TICK_MAX_DEF = int'(CYC_PER_MIN / longint'(BPM_MIN * CLKS_PER_QN));
  localparam int TICK_DFLT_DEF = int'(CYC_PER_MIN / longint'(BPM_DFLT * CLKS_PER_QN));
  localparam int CNT_W = 23;
  // parser states
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_DATA = 2'b01, RX_SYSEX = 2'b10} mcr_rx_e;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mcr_byte_s;
endpackage

// file: rtl/mcr_router.sv
// midi control router: parser, thru filter, controller map, tempo, lfos and noise
module mcr_router #(
  parameter int TICK_CYC_MIN = mcr_pkg::TICK_MIN_DEF,
  parameter int TICK_CYC_MAX = mcr_pkg::TICK_MAX_DEF,
  parameter int TICK_CYC_DFLT = mcr_pkg::TICK_DFLT_DEF,
  parameter int CLK_TIMEOUT_CYC = 2 * mcr_pkg::TICK_MAX_DEF
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // midi byte streams
  input wire mcr_pkg::mcr_byte_s midi_in,
  output logic rx_ready,
  output mcr_pkg::mcr_byte_s midi_out,
  input wire logic tx_ready,
  // modulation sources
  output logic [7:0] white_noise,
  output logic [7:0] pink_noise,
  output logic [7:0] note_lfo_phase
);
  import mcr_pkg::*;

  function automatic logic [3:0] cc_slot(input logic [6:0] cc);
    case (cc)
      CC_VIB: cc_slot = 4'h0;
      CC_MIX: cc_slot = 4'h1;
      CC_GLIDE: cc_slot = 4'h2;
      CC_VOL: cc_slot = 4'h3;
      CC_CUT_A: cc_slot = 4'h4;
      CC_SUS: cc_slot = 4'h5;
      CC_GON: cc_slot = 4'h6;
      CC_BYP: cc_slot = 4'h7;
      CC_PDEC: cc_slot = 4'h8;
      CC_BTOG: cc_slot = 4'h9;
      CC_CUT_B: cc_slot = 4'hA;
      default: cc_slot = SLOT_NONE;
    endcase
  endfunction

  function automatic logic [6:0] clamp_step(input logic [6:0] v);
    if (v < SYNC_STEP_LO) begin
      clamp_step = SYNC_STEP_LO;
    end else if (v > SYNC_STEP_HI) begin
      clamp_step = SYNC_STEP_HI;
    end else begin
      clamp_step = v;
    end
  endfunction

  function automatic logic [6:0] note_ticks(input logic [3:0] idx);
    case (idx)
      4'h0: note_ticks = 7'h60;
      4'h1: note_ticks = 7'h30;
      4'h2: note_ticks = 7'h18;
      4'h3: note_ticks = 7'h0C;
      4'h4: note_ticks = 7'h06;
      4'h5: note_ticks = 7'h03;
      4'h6: note_ticks = 7'h10;
      4'h7: note_ticks = 7'h08;
      4'h8: note_ticks = 7'h09;
      4'h9: note_ticks = 7'h04;
      4'hA: note_ticks = 7'h24;
      default: note_ticks = 7'h12;
    endcase
  endfunction

  // ahb-lite slave, zero wait reads, one wait write
  logic hreadyout_ff, wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff, rd_data;
  logic ap_ok;
  assign ap_ok = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end else begin
      hreadyout_ff <= 1'b1;
      wr_pend_ff <= 1'b0;
      if (ap_ok && hwrite) begin
        hreadyout_ff <= 1'b0;
        wr_pend_ff <= (haddr[31:8] == 24'h000000);
        wr_addr_ff <= haddr[7:0];
      end
      if (ap_ok && !hwrite) begin
        hrdata_ff <= (haddr[31:8] == 24'h000000) ? rd_data : 32'h00000000;
      end
    end
  end
  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;

  logic wr_ctrl, wr_rate, wr_src, wr_prog;
  assign wr_ctrl = wr_pend_ff && (wr_addr_ff == OFS_CTRL);
  assign wr_rate = wr_pend_ff && (wr_addr_ff == OFS_RATE);
  assign wr_src = wr_pend_ff && (wr_addr_ff == OFS_SRCSEL);
  assign wr_prog = wr_pend_ff && (wr_addr_ff == OFS_PROG);

  // global settings
  logic [4:0] chan_ff;
  logic thru_ff, sync_ff, dest_ff, notemode_ff, sync_tog;
  assign sync_tog = wr_ctrl && (hwdata[CTRL_SYNC_BIT] != sync_ff);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_ff <= CHAN_ALL;
      thru_ff <= 1'b0;
      sync_ff <= 1'b0;
      dest_ff <= 1'b0;
      notemode_ff <= 1'b0;
    end else if (wr_ctrl) begin
      chan_ff <= hwdata[CTRL_CHAN_LSB +: 5];
      thru_ff <= hwdata[CTRL_THRU_BIT];
      sync_ff <= hwdata[CTRL_SYNC_BIT];
      dest_ff <= hwdata[CTRL_DEST_BIT];
      notemode_ff <= hwdata[CTRL_NOTE_BIT];
    end
  end

  // shared rate control and pink cutoff
  logic [6:0] rate_ff, cut_ff, rate_eff, cut_eff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_ff <= RATE_MIN;
      cut_ff <= RATE_MIN;
    end else if (sync_tog) begin
      rate_ff <= RATE_MIN;
      cut_ff <= RATE_MIN;
    end else if (wr_rate) begin
      rate_ff <= hwdata[6:0];
      if (!dest_ff) begin
        cut_ff <= hwdata[6:0];
      end
    end
  end
  assign rate_eff = sync_ff ? clamp_step(rate_ff) : rate_ff;
  assign cut_eff = sync_ff ? clamp_step(cut_ff) : cut_ff;

  // midi parser
  mcr_rx_e rx_st_ff;
  logic [7:0] run_st_ff, d1_ff, b;
  logic got_ff, byte_in, rt_evt, msg_done;
  logic [7:0] msg_st, msg_d1, msg_d2;
  logic [1:0] msg_len, need;
  assign b = midi_in.data;
  assign byte_in = midi_in.valid && rx_ready;
  assign rt_evt = byte_in && (b >= SYS_RT_LO);
  always_comb begin
    need = 2'd2;
    if (run_st_ff[7:4] == ST_PC || run_st_ff[7:4] == 4'hD) begin
      need = 2'd1;
    end else if (run_st_ff[7:4] == 4'hF) begin
      need = (run_st_ff[3:0] == 4'h2) ? 2'd2 : 2'd1;
    end
    msg_done = 1'b0;
    msg_st = run_st_ff;
    msg_d1 = b;
    msg_d2 = 8'h00;
    msg_len = need + 2'd1;
    if (byte_in && !rt_evt && b[7] && b[7:4] == 4'hF && b != SYS_SYSEX
        && b[3:0] != 4'h1 && b[3:0] != 4'h2 && b[3:0] != 4'h3 && b[3:0] != 4'h7) begin
      msg_done = 1'b1;
      msg_st = b;
      msg_len = 2'd1;
    end else if (byte_in && !b[7] && rx_st_ff == RX_DATA) begin
      msg_done = (need == 2'd1) || got_ff;
      msg_d1 = got_ff ? d1_ff : b;
      msg_d2 = b;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_ff <= RX_IDLE;
      run_st_ff <= 8'h00;
      d1_ff <= 8'h00;
      got_ff <= 1'b0;
    end else if (byte_in && !rt_evt) begin
      if (b == SYS_SYSEX) begin
        rx_st_ff <= RX_SYSEX;
      end else if (b[7] && !msg_done && b != 8'hF7) begin
        rx_st_ff <= RX_DATA;
        run_st_ff <= b;
        got_ff <= 1'b0;
      end else if (b[7]) begin
        rx_st_ff <= RX_IDLE;
      end else if (rx_st_ff == RX_DATA) begin
        got_ff <= !msg_done;
        d1_ff <= b;
        if (msg_done && run_st_ff[7:4] == 4'hF) begin
          rx_st_ff <= RX_IDLE;
        end
      end
    end
  end

  // message classification
  logic chan_ok, cc_hit, pc_rx, note_on_evt, fwd_ok, tick;
  logic [3:0] slot;
  assign chan_ok = (chan_ff == CHAN_ALL) || ({1'b0, msg_st[3:0]} == chan_ff - 5'd1);
  assign slot = cc_slot(msg_d1[6:0]);
  logic [10:0] ovr_ff;
  assign cc_hit = msg_done && chan_ok && msg_st[7:4] == ST_CC && slot != SLOT_NONE
                  && !ovr_ff[slot];
  assign pc_rx = msg_done && chan_ok && msg_st[7:4] == ST_PC;
  assign note_on_evt = msg_done && chan_ok && msg_st[7:4] == ST_NOTE_ON && msg_d2 != 8'h00;
  assign fwd_ok = thru_ff && !(msg_st[7:4] == ST_CC && (msg_d1[6:0] == CC_DATA
                  || msg_d1[6:0] == CC_NRPN_L || msg_d1[6:0] == CC_NRPN_M));
  assign tick = rt_evt && b == SYS_CLOCK;

  // default mapping overrides and program
  logic [6:0] prog_ff;
  logic pc_pend_ff, pc_load, cc_pdec, prog_evt, reload;
  logic [3:0] src_slot;
  assign src_slot = cc_slot(hwdata[6:0]);
  assign cc_pdec = cc_hit && slot == 4'h8;
  assign prog_evt = wr_prog || cc_pdec || pc_rx;
  assign reload = prog_evt || wr_src;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovr_ff <= 11'h000;
    end else if (wr_src && src_slot != SLOT_NONE) begin
      ovr_ff[src_slot] <= 1'b1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_ff <= 7'h00;
      pc_pend_ff <= 1'b0;
    end else begin
      pc_pend_ff <= (pc_pend_ff && !pc_load) || wr_prog || cc_pdec;
      if (wr_prog) begin
        prog_ff <= hwdata[6:0];
      end else if (cc_pdec) begin
        prog_ff <= prog_ff - 7'd1;
      end else if (pc_rx) begin
        prog_ff <= msg_d1[6:0];
      end
    end
  end

  // controller destinations
  logic [6:0] vib_ff, mix_ff, glide_ff, vol_ff, fcut_ff, sus_ff, gon_ff;
  logic byp_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vib_ff <= DEF_VIB;
      mix_ff <= DEF_MIX;
      glide_ff <= DEF_GLIDE;
      vol_ff <= DEF_VOL;
      fcut_ff <= DEF_CUT;
      sus_ff <= DEF_SUS;
      gon_ff <= DEF_GON;
      byp_ff <= 1'b0;
    end else if (reload) begin
      vib_ff <= DEF_VIB;
      mix_ff <= DEF_MIX;
      glide_ff <= DEF_GLIDE;
      vol_ff <= DEF_VOL;
      fcut_ff <= DEF_CUT;
      sus_ff <= DEF_SUS;
      gon_ff <= DEF_GON;
    end else if (cc_hit) begin
      case (slot)
        4'h0: vib_ff <= msg_d2[6:0];
        4'h1: mix_ff <= msg_d2[6:0];
        4'h2: glide_ff <= msg_d2[6:0];
        4'h3: vol_ff <= msg_d2[6:0];
        4'h4, 4'hA: fcut_ff <= msg_d2[6:0];
        4'h5: sus_ff <= msg_d2[6:0];
        4'h6: gon_ff <= msg_d2[6:0];
        4'h7: byp_ff <= (msg_d2[6:0] >= CC_ON_TH);
        4'h9: byp_ff <= byp_ff ^ (msg_d2[6:0] >= CC_ON_TH);
        default: byp_ff <= byp_ff;
      endcase
    end else if (note_on_evt && notemode_ff) begin
      fcut_ff <= msg_d2[6:0];
    end
  end

  // output emitter
  logic [2:0][7:0] em_q_ff;
  logic [1:0] em_n_ff, em_n_nxt;
  mcr_byte_s out_ff;
  logic rx_ready_ff, ld_msg, ld_rt;
  logic [3:0] tx_ch;
  assign tx_ch = (chan_ff == CHAN_ALL) ? 4'h0 : 4'(chan_ff - 5'd1);
  assign ld_msg = msg_done && fwd_ok;
  assign ld_rt = rt_evt && thru_ff;
  assign pc_load = pc_pend_ff && em_n_ff == 2'd0 && !ld_msg && !ld_rt;
  always_comb begin
    em_n_nxt = em_n_ff;
    if (ld_msg) begin
      em_n_nxt = msg_len;
    end else if (ld_rt) begin
      em_n_nxt = 2'd1;
    end else if (pc_load) begin
      em_n_nxt = 2'd2;
    end else if (em_n_ff != 2'd0 && (!out_ff.valid || tx_ready)) begin
      em_n_nxt = em_n_ff - 2'd1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      em_q_ff <= '0;
      em_n_ff <= 2'd0;
      out_ff <= '0;
      rx_ready_ff <= 1'b0;
    end else begin
      em_n_ff <= em_n_nxt;
      rx_ready_ff <= (em_n_nxt == 2'd0);
      if (ld_msg) begin
        em_q_ff <= {msg_d2, msg_d1, msg_st};
      end else if (ld_rt) begin
        em_q_ff <= {16'h0000, b};
      end else if (pc_load) begin
        em_q_ff <= {8'h00, 1'b0, prog_ff, ST_PC, tx_ch};
      end else if (em_n_ff != 2'd0 && (!out_ff.valid || tx_ready)) begin
        em_q_ff <= {8'h00, em_q_ff[2], em_q_ff[1]};
      end
      if (!out_ff.valid || tx_ready) begin
        out_ff.valid <= (em_n_ff != 2'd0) && !pc_load;
        out_ff.data <= em_q_ff[0];
      end
    end
  end
  assign rx_ready = rx_ready_ff;
  assign midi_out = out_ff;

  // tempo measurement
  logic [CNT_W-1:0] gap_ff, period_ff, gap_inc;
  logic present_ff;
  assign gap_inc = gap_ff + 1'b1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_ff <= '0;
      period_ff <= CNT_W'(TICK_CYC_DFLT);
      present_ff <= 1'b0;
    end else begin
      if (tick) begin
        gap_ff <= '0;
        present_ff <= 1'b1;
        if (present_ff) begin
          period_ff <= (gap_inc < CNT_W'(TICK_CYC_MIN)) ? CNT_W'(TICK_CYC_MIN) :
                       (gap_inc > CNT_W'(TICK_CYC_MAX)) ? CNT_W'(TICK_CYC_MAX) : gap_inc;
        end
      end else begin
        if (gap_ff != CNT_W'(CLK_TIMEOUT_CYC)) begin
          gap_ff <= gap_inc;
        end else begin
          present_ff <= 1'b0;
        end
        if (prog_evt && !present_ff && sync_ff) begin
          period_ff <= CNT_W'(TICK_CYC_DFLT);
        end
      end
    end
  end

  // note synchronised lfo, free or tempo locked
  logic [CNT_W-1:0] sc_cyc_ff;
  logic [6:0] sc_tick_ff;
  logic [23:0] nr_acc_ff;
  logic [3:0] nl_idx;
  assign nl_idx = 4'(rate_eff - SYNC_STEP_LO);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sc_cyc_ff <= '0;
      sc_tick_ff <= 7'h00;
      nr_acc_ff <= 24'h000000;
    end else if (note_on_evt) begin
      sc_cyc_ff <= '0;
      sc_tick_ff <= 7'h00;
      nr_acc_ff <= 24'h000000;
    end else begin
      nr_acc_ff <= nr_acc_ff + {17'h00000, rate_eff} + 24'h000001;
      if (sc_cyc_ff >= period_ff - 1'b1) begin
        sc_cyc_ff <= '0;
        sc_tick_ff <= (sc_tick_ff >= note_ticks(nl_idx) - 7'd1) ? 7'h00 : sc_tick_ff + 7'd1;
      end else begin
        sc_cyc_ff <= sc_cyc_ff + 1'b1;
      end
    end
  end

  // fast free lfo, white and pink noise
  logic [24:0] ff_sum;
  logic [23:0] ff_acc_ff;
  logic [15:0] lfsr_ff;
  logic [7:0] white_ff, pink_ff, phase_ff;
  logic signed [17:0] pink_step;
  assign ff_sum = {1'b0, ff_acc_ff} + {15'h0000, {1'b0, rate_eff} + 8'h01, 2'b00};
  assign pink_step = ($signed({10'h000, white_ff}) - $signed({10'h000, pink_ff}))
                     * $signed({10'h000, 1'b0, cut_eff} + 18'sd1) >>> 7;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ff_acc_ff <= 24'h000000;
      lfsr_ff <= LFSR_SEED;
      white_ff <= 8'h00;
      pink_ff <= 8'h00;
      phase_ff <= 8'h00;
    end else begin
      ff_acc_ff <= ff_sum[23:0];
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      phase_ff <= sync_ff ? {1'b0, sc_tick_ff} : nr_acc_ff[23:16];
      if (ff_sum[24]) begin
        white_ff <= lfsr_ff[7:0];
        pink_ff <= 8'(18'($signed({10'h000, pink_ff}) + pink_step));
      end
    end
  end
  assign white_noise = white_ff;
  assign pink_noise = pink_ff;
  assign note_lfo_phase = phase_ff;

  // register read mux
  always_comb begin
    case (haddr[7:0])
      OFS_CTRL: rd_data = {23'h0, notemode_ff, dest_ff, sync_ff, thru_ff, chan_ff};
      OFS_RATE: rd_data = {17'h0, cut_ff, 1'b0, rate_ff};
      OFS_SRCSEL: rd_data = {21'h0, ovr_ff};
      OFS_PROG: rd_data = {25'h0, prog_ff};
      OFS_STAT: rd_data = {1'b0, prog_ff, present_ff, period_ff};
      OFS_DEST0: rd_data = {1'b0, fcut_ff, 1'b0, vol_ff, 1'b0, glide_ff, 1'b0, vib_ff};
      OFS_DEST1: rd_data = {7'h0, byp_ff, 1'b0, gon_ff, 1'b0, sus_ff, 1'b0, mix_ff};
      OFS_NOISE: rd_data = {8'h0, phase_ff, pink_ff, white_ff};
      default: rd_data = 32'h00000000;
    endcase
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_noise_held: assert property (!ff_sum[24] |=> white_ff == $past(white_ff))
    else $error("white noise changed without lfo wrap");
  a_pink_frozen: assert property (dest_ff && wr_rate && !sync_tog |=> $stable(cut_ff))
    else $error("pink cutoff moved while rate is a destination");
  a_sync_reset: assert property (sync_tog |=> rate_ff == RATE_MIN && cut_ff == RATE_MIN)
    else $error("sync toggle did not reset rate");
  a_step_range: assert property (
    sync_ff |-> rate_eff inside {[SYNC_STEP_LO:SYNC_STEP_HI]}
    && cut_eff inside {[SYNC_STEP_LO:SYNC_STEP_HI]})
    else $error("sync step range exceeded");
  a_tempo_clamp: assert property (
    period_ff >= CNT_W'(TICK_CYC_MIN) && period_ff <= CNT_W'(TICK_CYC_MAX))
    else $error("tempo period out of range");
  a_dflt_tempo: assert property (prog_evt && !present_ff && sync_ff && !tick
    |=> period_ff == CNT_W'(TICK_CYC_DFLT))
    else $error("default tempo not applied");
  a_cc_reload: assert property (reload |=> vol_ff == DEF_VOL && fcut_ff == DEF_CUT)
    else $error("defaults not reloaded");
  a_pc_channel: assert property (
    pc_load |=> em_q_ff[0] == {ST_PC, $past(tx_ch)} && em_n_ff == 2'd2)
    else $error("program change on wrong channel");
  a_no_data_cc: assert property (msg_done && msg_st[7:4] == ST_CC && msg_d1[6:0] == CC_DATA
    && !pc_pend_ff |=> em_n_ff == 2'd0)
    else $error("controller 6 forwarded");
  a_thru_off: assert property (byte_in && !thru_ff && !pc_pend_ff |=> em_n_ff == 2'd0)
    else $error("forwarded with thru off");
  a_rx_pc_quiet: assert property (pc_rx && !pc_pend_ff && !wr_prog |=> !pc_pend_ff)
    else $error("received program change echoed");
  a_note_phase: assert property (note_on_evt |=> sc_cyc_ff == '0 && nr_acc_ff == 24'h000000)
    else $error("note did not reset lfo phase");
  c_pc_out: cover property (pc_load ##[1:4] out_ff.valid);
  c_tempo: cover property (tick && present_ff);
  c_sync_note: cover property (note_on_evt && sync_ff);
  c_noise: cover property (ff_sum[24]);
endmodule

// file: testbench/mcr_midi_src.sv
// midi source model that feeds bytes into the router
module mcr_midi_src
  import mcr_pkg::*;
(
  // clock and handshake
  input wire logic clk,
  input wire logic rx_ready,
  // byte stream
  output mcr_pkg::mcr_byte_s midi_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial midi_in = '{valid: 1'b0, data: 8'h00};
  // hold a byte until taken, then show a changed idle value for one cycle
  task automatic send(input logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    midi_in <= '{valid: 1'b1, data: b};
    @(posedge clk);
    while (rx_ready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    ok = (n < 100);
    midi_in <= '{valid: 1'b0, data: ~b};
    @(posedge clk);
  endtask
endmodule

// file: testbench/tb_midi_control_router.sv
// bench for the midi control router
module tb_midi_control_router;
  timeunit 1ns;
  timeprecision 1ps;
  import mcr_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic hrdy, hresp, rx_ready;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [1:0] htrans = 2'h0;
  logic tx_rdy = 1'b1;
  logic [7:0] wht, pnk, lph;
  mcr_byte_s midi_in, midi_out;
  logic [7:0] outq[$];
  int err_total = 0;
  int check_count = 0;
  initial forever #12.5 hclk = ~hclk;
  mcr_midi_src src (.clk(hclk), .rx_ready(rx_ready), .midi_in(midi_in));
  mcr_router #(.TICK_CYC_MIN(20), .TICK_CYC_MAX(200), .TICK_CYC_DFLT(50),
    .CLK_TIMEOUT_CYC(400)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp),
    .midi_in(midi_in), .rx_ready(rx_ready), .midi_out(midi_out), .tx_ready(tx_rdy),
    .white_noise(wht), .pink_noise(pnk), .note_lfo_phase(lph));
  always @(posedge hclk) begin
    if (midi_out.valid === 1'b1 && tx_rdy === 1'b1) outq.push_back(midi_out.data);
  end
  task automatic stop_test();
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hrdy !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        stop_test();
      end
      @(posedge hclk);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic ticks(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      snd(SYS_CLOCK);
      repeat (gap - 2) @(posedge hclk);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(hrdata, e);
  endtask
  task automatic snd(input logic [7:0] b);
    logic ok;
    src.send(b, ok);
    if (ok !== 1'b1) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic cc(input logic [3:0] ch, input logic [6:0] n, input logic [6:0] v);
    snd({4'hB, ch});
    snd({1'b0, n});
    snd({1'b0, v});
  endtask
  task automatic out_is(input logic [23:0] e, input int n);
    int k;
    k = 0;
    while (outq.size() < n && k < 40) begin
      k++;
      @(posedge hclk);
    end
    repeat (4) @(posedge hclk);
    chk(outq.size(), n);
    for (int i = 0; i < n && i < outq.size(); i++) chk(outq[i], e[8*(n-1-i)+:8]);
    outq.delete();
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_DEST0, 32'h407F0000);
    rd(OFS_DEST1, 32'h007F007F);
    cc(4'h0, CC_VOL, 7'h10);
    cc(4'h0, CC_SUS, 7'h7F);
    rd(OFS_DEST0, 32'h40100000);
    rd(OFS_DEST1, 32'h007F7F7F);
    ahb(1'b1, OFS_CTRL, 32'h2);
    cc(4'h0, CC_VOL, 7'h20);
    cc(4'h1, CC_VOL, 7'h30);
    rd(OFS_DEST0, 32'h40300000);
    tx_rdy <= 1'b0;
    ahb(1'b1, OFS_PROG, 32'h5);
    repeat (6) @(posedge hclk);
    tx_rdy <= 1'b1;
    out_is(24'hC105, 2);
    rd(OFS_DEST0, 32'h407F0000);
    ahb(1'b1, OFS_CTRL, 32'h0);
    ahb(1'b1, OFS_PROG, 32'h3);
    out_is(24'hC003, 2);
    ahb(1'b1, OFS_CTRL, 32'h20);
    snd(8'hF0);
    snd(8'h01);
    snd(8'hF7);
    cc(4'h0, CC_DATA, 7'h01);
    cc(4'h0, CC_VOL, 7'h11);
    out_is(24'hB00711, 3);
    ahb(1'b1, OFS_CTRL, 32'h0);
    cc(4'h0, CC_VOL, 7'h22);
    snd(8'hC0);
    snd(8'h09);
    out_is(24'h0, 0);
    rd(OFS_DEST0, 32'h407F0000);
    ahb(1'b1, OFS_RATE, 32'h30);
    rd(OFS_RATE, 32'h3030);
    ahb(1'b1, OFS_CTRL, 32'h40);
    rd(OFS_RATE, 32'h0);
    ahb(1'b1, OFS_CTRL, 32'h80);
    ahb(1'b1, OFS_RATE, 32'h5);
    rd(OFS_RATE, 32'h5);
    ticks(2, 250);
    rd(OFS_STAT, 32'h098000C8);
    ticks(2, 10);
    rd(OFS_STAT, 32'h09800014);
    ticks(3, 30);
    rd(OFS_STAT, 32'h0980001E);
    ahb(1'b1, OFS_CTRL, 32'h140);
    repeat (450) @(posedge hclk);
    ahb(1'b1, OFS_PROG, 32'h11);
    out_is(24'hC011, 2);
    rd(OFS_STAT, 32'h11000032);
    ahb(1'b1, OFS_RATE, 32'h6);
    snd(8'h90);
    snd(8'h3C);
    snd(8'h50);
    repeat (2) @(posedge hclk);
    chk(lph, 8'h00);
    repeat (222) @(posedge hclk);
    chk(lph, 8'h01);
    rd(OFS_NOISE, 32'h00010000);
    chk({wht, pnk}, 16'h0000);
    rd(OFS_DEST0, 32'h507F0000);
    ahb(1'b1, OFS_SRCSEL, 32'h2);
    cc(4'h0, CC_MIX, 7'h05);
    cc(4'h0, CC_GLIDE, 7'h05);
    rd(OFS_DEST1, 32'h007F007F);
    rd(OFS_DEST0, 32'h407F0500);
    rd(OFS_SRCSEL, 32'h2);
    cc(4'h0, CC_BYP, 7'h7F);
    rd(OFS_DEST1, 32'h017F007F);
    cc(4'h0, CC_BTOG, 7'h7F);
    rd(OFS_DEST1, 32'h007F007F);
    cc(4'h0, CC_PDEC, 7'h00);
    out_is(24'hC010, 2);
    rd(OFS_PROG, 32'h10);
    stop_test();
  end
endmodule
